/* verilog/glock_pkg.sv */
// Purpose: Shared constants and types for the guard lock output logic
// Assumes: 100 MHz clock, all inputs synchronous to clk_in
// Notes:   Times are in their own units; cycle counts derive from them
package glock_pkg;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int unsigned CLK_FREQ_HZ     = 100_000_000;
   localparam int unsigned RELOCK_WAIT_MS  = 500;
   localparam int unsigned RELOCK_WAIT_CYC =
      (RELOCK_WAIT_MS * (CLK_FREQ_HZ / 1000));
   localparam int unsigned HOLD_TEST_US    = 20;
   localparam int unsigned HOLD_TEST_CYC   =
      (HOLD_TEST_US * (CLK_FREQ_HZ / 1_000_000));
   localparam int unsigned CNT_W           = 26;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic        SAFE_RST        = 1'h0;
   localparam logic        MAGNET_RST      = 1'h0;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      GLOCK_ST_TEST,
      GLOCK_ST_RUN,
      GLOCK_ST_LOCK_ERR,
      GLOCK_ST_FAULT
   } glock_state_e;

   // Sensing inputs from the gate and magnet front end
   typedef struct packed {
      logic actuator_present;
      logic winding_open;
      logic winding_short;
      logic hold_ok;
      logic hold_done;
   } glock_sense_s;

   // Status levels towards the indicator logic
   typedef struct packed {
      logic ready;
      logic locked;
      logic lock_error;
      logic fault;
   } glock_status_s;

endpackage

/* verilog/glock_output_logic.sv */
// Purpose: Safety output and magnetic guard lock decision logic
// Assumes: Sensing front end reports actuator presence, winding faults and
//          holding-force test result as synchronous levels
// Notes:   Power-up equals reset release; fault clears only by reset
// Behaviour
// - Outputs high only when all three hold
// - Energise magnet on request with gate closed
// - Test holding force after power up
// - Winding open or short forces outputs low
// - Forced opening while locked drops outputs
// - Any matching actuator detected immediately
// - Fault state held until power cycle
// - Failed lock flags error until relock
`timescale 1ns/100ps
module glock_output_logic #(
   parameter int unsigned RELOCK_CYC = glock_pkg::RELOCK_WAIT_CYC,
   parameter int unsigned HOLD_CYC   = glock_pkg::HOLD_TEST_CYC
) (
   input  wire logic                     clk_in,
   input  wire logic                     reset_n_in,
   input  wire logic                     lock_request_input_in,
   input  wire glock_pkg::glock_sense_s  sense_in,
   output logic                          safe_out_ch1_out,
   output logic                          safe_out_ch2_out,
   output logic                          magnet_on_out,
   output logic                          hold_test_out,
   output glock_pkg::glock_status_s      status_out
);
   import glock_pkg::*;

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------

   // Control state and registered outputs
   glock_state_e            state_q,    state_d;
   logic                    safe_q,     safe_d;
   logic                    magnet_q,   magnet_d;
   logic                    test_q,     test_d;
   glock_status_s           status_q,   status_d;

   // Low-phase timer of the lock request
   logic [CNT_W-1:0]        cnt_q,      cnt_d;
   logic                    req_low_q,  req_low_d;

   // Holding-force test watchdog
   logic [CNT_W-1:0]        tcnt_q,     tcnt_d;

   // Derived conditions
   logic                    winding_bad;
   logic                    wait_done;
   logic                    test_expired;
   logic                    gate_ok;

   // ------------------------------------------------------------------
   // Derived conditions
   // ------------------------------------------------------------------

   // Winding is only meaningful while the magnet carries current
   assign winding_bad  = magnet_q &
                         (sense_in.winding_open | sense_in.winding_short);

   // Low phase long enough to allow a relock
   assign wait_done    = (cnt_q >= CNT_W'(RELOCK_CYC));

   // Test that never reports must not hold the unit in test forever
   assign test_expired = (tcnt_q >= CNT_W'(HOLD_CYC));

   // Request present and gate closed
   assign gate_ok      = lock_request_input_in &
                         sense_in.actuator_present;

   // ------------------------------------------------------------------
   // Low-phase timer
   // ------------------------------------------------------------------

   always_comb begin
      cnt_d     = cnt_q;
      req_low_d = req_low_q;
      if (lock_request_input_in) begin
         // Any high level restarts the low-phase measurement
         cnt_d     = '0;
         req_low_d = 1'b0;
      end else begin
         req_low_d = 1'b1;
         if (!wait_done) begin
            // Saturates so a long low phase cannot wrap to a short one
            cnt_d = cnt_q + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cnt_q     <= '0;
         req_low_q <= 1'b0;
      end else begin
         cnt_q     <= cnt_d;
         req_low_q <= req_low_d;
      end
   end

   // ------------------------------------------------------------------
   // Holding-force test watchdog
   // ------------------------------------------------------------------

   always_comb begin
      tcnt_d = tcnt_q;
      if (state_q != GLOCK_ST_TEST) begin
         tcnt_d = '0;
      end else if (!test_expired) begin
         tcnt_d = tcnt_q + CNT_W'(1);
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tcnt_q <= '0;
      end else begin
         tcnt_q <= tcnt_d;
      end
   end

   // ------------------------------------------------------------------
   // Control next state
   // ------------------------------------------------------------------

   always_comb begin
      state_d  = state_q;
      magnet_d = MAGNET_RST;
      test_d   = 1'b0;
      safe_d   = SAFE_RST;
      case (state_q)
         GLOCK_ST_TEST: begin
            // Magnet driven for the holding-force test
            magnet_d = 1'b1;
            test_d   = 1'b1;
            if (winding_bad) begin
               // Winding is watched whenever the magnet is energised
               magnet_d = 1'b0;
               test_d   = 1'b0;
               state_d  = GLOCK_ST_FAULT;
            end else if (sense_in.hold_done) begin
               magnet_d = 1'b0;
               test_d   = 1'b0;
               if (sense_in.hold_ok) begin
                  state_d = GLOCK_ST_RUN;
               end else begin
                  state_d = GLOCK_ST_FAULT;
               end
            end else if (test_expired) begin
               // No result in time counts as a failed test
               magnet_d = 1'b0;
               test_d   = 1'b0;
               state_d  = GLOCK_ST_FAULT;
            end
         end
         GLOCK_ST_RUN: begin
            // Presence is a plain level: no teach-in gating
            magnet_d = gate_ok;
            safe_d   = gate_ok;
            if (winding_bad) begin
               safe_d   = 1'b0;
               magnet_d = 1'b0;
               state_d  = GLOCK_ST_FAULT;
            end else if (lock_request_input_in &&
                         !sense_in.actuator_present) begin
               // Covers gate forced open while locked, or never closed
               safe_d   = 1'b0;
               state_d  = GLOCK_ST_LOCK_ERR;
            end
         end
         GLOCK_ST_LOCK_ERR: begin
            // Relock only after a low phase of at least the wait time
            if (lock_request_input_in && req_low_q && wait_done) begin
               state_d = GLOCK_ST_RUN;
            end
         end
         default: begin
            // Latched until power cycle; nothing leaves this state
            state_d = GLOCK_ST_FAULT;
         end
      endcase
      status_d.ready      = (state_d == GLOCK_ST_RUN);
      status_d.locked     = magnet_d & (state_d == GLOCK_ST_RUN);
      status_d.lock_error = (state_d == GLOCK_ST_LOCK_ERR);
      status_d.fault      = (state_d == GLOCK_ST_FAULT);
   end

   // ------------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------------

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_q  <= GLOCK_ST_TEST;
         safe_q   <= SAFE_RST;
         magnet_q <= MAGNET_RST;
         test_q   <= 1'b0;
         status_q <= '0;
      end else begin
         state_q  <= state_d;
         safe_q   <= safe_d;
         magnet_q <= magnet_d;
         test_q   <= test_d;
         status_q <= status_d;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------

   // One flop feeds both channels so they can never disagree
   assign safe_out_ch1_out = safe_q;
   assign safe_out_ch2_out = safe_q;
   assign magnet_on_out    = magnet_q;
   assign hold_test_out    = test_q;
   assign status_out       = status_q;

endmodule // glock_output_logic

/* sim/glock_assertions.sv */
// Purpose: Port checks on the guard lock output logic
// Assumes: One clock, async active-low reset
// Notes:   Bound to the glock_output_logic module
`timescale 1ns/100ps
module glock_assertions (
   input wire logic                     clk_in,
   input wire logic                     reset_n_in,
   input wire logic                     lock_request_input_in,
   input wire glock_pkg::glock_sense_s  sense_in,
   input wire logic                     safe_out_ch1_out,
   input wire logic                     safe_out_ch2_out,
   input wire logic                     magnet_on_out,
   input wire logic                     hold_test_out,
   input wire glock_pkg::glock_status_s status_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   sequence s_pass;
      hold_test_out && sense_in.hold_done && sense_in.hold_ok &&
      !sense_in.winding_open && !sense_in.winding_short;
   endsequence
   a_chan_same: assert property (safe_out_ch1_out == safe_out_ch2_out)
      else $error("safety channels differ");
   a_safe_cause: assert property (safe_out_ch1_out |-> $past(
      lock_request_input_in && sense_in.actuator_present)) else $error("safe");
   a_lock_on: assert property (status_out.ready && lock_request_input_in &&
      sense_in.actuator_present && !status_out.lock_error && !status_out.fault
      && !sense_in.winding_open && !sense_in.winding_short
      |=> magnet_on_out && safe_out_ch1_out) else $error("no lock");
   a_wind_fault: assert property (magnet_on_out && (sense_in.winding_open ||
      sense_in.winding_short) |=> !safe_out_ch1_out && status_out.fault)
      else $error("winding fault missed");
   a_fault_hold: assert property (status_out.fault |=>
      status_out.fault && !safe_out_ch1_out) else $error("fault left");
   a_test_start: assert property ($rose(reset_n_in) |=>
      hold_test_out && magnet_on_out) else $error("no hold test");
   a_test_pass: assert property (s_pass |=> !hold_test_out && status_out.ready)
      else $error("test pass");
   a_test_fail: assert property (hold_test_out && sense_in.hold_done &&
      !sense_in.hold_ok |=> status_out.fault) else $error("test fail");
endmodule // glock_assertions
bind glock_output_logic glock_assertions u_chk (.clk_in, .reset_n_in,
   .lock_request_input_in, .sense_in, .safe_out_ch1_out, .safe_out_ch2_out,
   .magnet_on_out, .hold_test_out, .status_out);

/* sim/glock_eval_model.sv */
// Purpose: Evaluation device raising the lock request
// Assumes: Driven from the rising clock edge
// Notes:   Early relock would be refused, so it waits MIN_LOW cycles
`timescale 1ns/100ps
module glock_eval_model #(
   parameter int unsigned MIN_LOW = 20
) (
   input  wire logic clk_in,
   input  wire logic reset_n_in,
   input  wire logic want_lock_in,
   output logic      req_out
);
   logic [7:0] low_q;
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         req_out <= 1'h0;
         low_q   <= 8'h0;
      end else begin
         req_out <= want_lock_in && (req_out || 32'(low_q) >= MIN_LOW);
         low_q   <= req_out ? 8'h0 : low_q + {7'h0, low_q != 8'hFF};
      end
   end
endmodule // glock_eval_model

/* sim/tb_top.sv */
// Purpose: Self-checking bench for the guard lock output logic
// Assumes: RELOCK_CYC shortened to 20 cycles
// Notes:   Rows are {present, want, safe, magnet}
`timescale 1ns/100ps
module tb_top;
   import glock_pkg::*;
   logic          clk_in = 1'h0;
   logic          reset_n_in = 1'h0;
   logic          want = 1'h0;
   logic          req, s1, s2, mag, tst;
   glock_sense_s  sense = '0;
   glock_status_s st;
   int            fails = 0;
   int            tests_run = 0;
   logic [3:0]    rows [5] = '{4'h8, 4'hF, 4'h8, 4'hF, 4'h4};
   always #5 clk_in = ~clk_in;
   glock_eval_model #(.MIN_LOW(20)) u_eval (.clk_in, .reset_n_in,
      .want_lock_in(want), .req_out(req));
   glock_output_logic #(.RELOCK_CYC(20)) uut (.clk_in, .reset_n_in,
      .lock_request_input_in(req), .sense_in(sense), .safe_out_ch1_out(s1),
      .safe_out_ch2_out(s2), .magnet_on_out(mag), .hold_test_out(tst),
      .status_out(st));
   task automatic chk(input logic [2:0] got, input logic [2:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %b want %b", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic go(input logic p, input logic w);
      @(posedge clk_in) #1;
      sense.actuator_present = p;
      want = w;
      for (int i = 0; i < 40 && req !== w; i++) @(posedge clk_in) #1;
      chk({req, 2'h0}, {w, 2'h0});
      if (req !== w) end_of_test();
      repeat (2) @(posedge clk_in);
      #1;
   endtask
   task automatic power_up(input logic ok);
      reset_n_in = 1'h0;
      sense = '0;
      sense.hold_ok = ok;
      want = 1'h0;
      repeat (5) @(posedge clk_in);
      #1 reset_n_in = 1'h1;
      repeat (3) @(posedge clk_in);
      #1 chk({tst, mag, s1}, 3'h6);
      sense.hold_done = 1'h1;
      repeat (2) @(posedge clk_in);
      #1 chk({st.fault, tst, s1}, {!ok, 2'h0});
   endtask
   initial begin
      power_up(1'h1);
      foreach (rows[i]) begin
         go(rows[i][3], rows[i][2]);
         chk({s1, s2, mag}, {rows[i][1], rows[i][1], rows[i][0]});
      end
      // Lock error must survive the gate closing again
      go(1'h1, 1'h1);
      chk({s1, st.lock_error, 1'h0}, 3'h2);
      go(1'h1, 1'h0);
      go(1'h1, 1'h1);
      chk({s1, st.lock_error, mag}, 3'h5);
      chk({st.ready, st.locked, st.fault}, 3'h6);
      @(posedge clk_in) #1 sense.winding_short = 1'h1;
      @(posedge clk_in) #1 sense.winding_short = 1'h0;
      chk({s1, st.fault, s2}, 3'h2);
      go(1'h1, 1'h0);
      go(1'h1, 1'h1);
      chk({s1, st.fault, s2}, 3'h2);
      power_up(1'h0);
      end_of_test();
   end
endmodule // tb_top
